// file: rtl/rsec_pkg.sv
package rsec_pkg;
    // register offsets
    localparam logic [7:0] REG2_PIN_CONTROL_OFS = 8'h40;
    localparam logic [7:0] REG3_CONFIG_OFS = 8'h41;
    localparam logic [7:0] REG3_VOLTAGE_CODE_OFS = 8'h42;
    localparam logic [7:0] REG3_PIN_CONTROL_OFS = 8'h43;
    localparam logic [7:0] SWITCH1_CONFIG_OFS = 8'h44;
    localparam logic [7:0] SWITCH1_PIN_CONTROL_OFS = 8'h45;
    localparam logic [7:0] SWITCH2_CONFIG_OFS = 8'h46;
    localparam logic [7:0] SWITCH2_PIN_CONTROL_OFS = 8'h47;
    // config and pin control register field positions
    localparam int CFG_EN_MSB = 4;
    localparam int CFG_EN_LSB = 3;
    localparam int CFG_ACT_BIT = 2;
    localparam int CFG_MODE_BIT = 1;
    localparam int CFG_PSV_BIT = 0;
    localparam int PIN_FN_ENABLE_BIT = 7;
    localparam int PIN_FN_SELECT_BIT = 6;
    // values after reset
    localparam logic [4:0] CFG_RESET = 5'h01;
    localparam logic [5:0] VCODE_RESET = 6'h00;
    localparam logic [1:0] R3_FN_RESET = 2'h0;
    localparam logic [3:0] R3_PIN_RESET = 4'h4;
    localparam logic [3:0] SW_PIN_RESET = 4'h0;
    localparam logic [3:0] R2_PIN_RESET = 4'h2;
    // boot slot codes
    localparam logic [2:0] SLOT_OFF = 3'h0;
    localparam logic [2:0] SLOT_AT0 = 3'h2;
    localparam logic [2:0] SLOT_AT25 = 3'h3;
    localparam logic [2:0] SLOT_AT50 = 3'h4;
    localparam logic [2:0] SLOT_SW = 3'h7;
    // software enable codes
    localparam logic [1:0] EN_OFF = 2'h0;
    localparam logic [1:0] EN_ON = 2'h1;
    localparam logic [1:0] EN_PIN = 2'h2;
    // boot delay figures and cycle counts
    localparam int CLK_KHZ = 40000;
    localparam int BOOT_DLY_80_MS = 80;
    localparam int BOOT_DLY_120_MS = 120;
    localparam int BOOT_DLY_220_MS = 220;
    localparam int BOOT_DLY_420_MS = 420;
    localparam int BOOT_DLY_80_CYC = BOOT_DLY_80_MS * CLK_KHZ;
    localparam int BOOT_DLY_120_CYC = BOOT_DLY_120_MS * CLK_KHZ;
    localparam int BOOT_DLY_220_CYC = BOOT_DLY_220_MS * CLK_KHZ;
    localparam int BOOT_DLY_420_CYC = BOOT_DLY_420_MS * CLK_KHZ;
    localparam int CNT_W = 25;
    localparam logic [CNT_W-1:0] CNT_RESET = 25'h0;
    // output index order in enable vectors
    localparam int IDX_R3 = 0;
    localparam int IDX_S1 = 1;
    localparam int IDX_S2 = 2;
    localparam int IDX_R2 = 3;

    // boot sequencing phase, one-hot
    typedef enum logic [2:0] {
        BOOT_IDLE = 3'b001,
        BOOT_RUN = 3'b010,
        BOOT_DONE = 3'b100
    } rsec_boot_t;

    // read-only slot codes and enable codes of the second regulator
    typedef struct packed {
        logic [2:0] reg3_boot_slot;
        logic [2:0] switch1_boot_slot;
        logic [2:0] switch2_boot_slot;
        logic [2:0] reg2_boot_slot;
        logic [1:0] reg2_sw_enable_code;
    } rsec_slots_t;

    // per-output analog controls
    typedef struct packed {
        logic [2:0] active_discharge;
        logic [2:0] passive_discharge;
        logic reg3_switch_mode;
        logic switch1_low_quiescent;
        logic switch2_low_quiescent;
        logic [5:0] reg3_voltage_code;
    } rsec_ctrl_t;

    // whole module state
    typedef struct packed {
        logic [3:0] pin_meta;
        logic [3:0] pin_sync;
        logic [1:0] dly_meta;
        logic [1:0] dly_sync;
        logic [4:0] r3_cfg;
        logic [5:0] r3_vcode;
        logic [1:0] r3_fn;
        logic [3:0] r3_pin;
        logic [4:0] s1_cfg;
        logic [3:0] s1_pin;
        logic [4:0] s2_cfg;
        logic [3:0] s2_pin;
        logic [3:0] r2_pin;
        rsec_boot_t boot;
        logic [CNT_W-1:0] cnt;
        logic [1:0] dly_sel;
        logic [2:0] mile;
        logic r3_mode;
        logic [3:0] en;
        logic [2:0] act;
        logic [2:0] psv;
        logic [7:0] rdata;
    } rsec_state_t;
endpackage

// file: rtl/rsec_top.sv
// Operation
// - second regulator follows OR of selected pins
// - reg3 slot code stages or hands over
// - reg3 software code: off, on, pins
// - reg3 active discharge in reset, optionally disabled
// - reg3 switch mode latched while disabled only
// - reg3 passive discharge also while disabled optionally
// - reg3 six-bit voltage code stored and output
// - reg3 follows OR of selected pins
// - pin zero function gated by enable bit
// - pin zero picks mode or enable
// - switch1 slot code stages or hands over
// - switch1 software code: off, on, pins
// - switch1 active discharge optionally when disabled
// - switch1 low quiescent bit drives protection off
// - switch1 passive discharge optionally while disabled
// - switch1 follows OR of selected pins
// - switch2 slot code stages or hands over
// - switch2 software code: off, on, pins
// - switch2 active discharge optionally when disabled
// - switch2 passive discharge optionally while disabled
// - switch2 low quiescent bit drives protection off
// - boot delay length chosen by two-bit code
// - switch2 follows OR of selected pins
`timescale 1ns/1ps
module rsec_top
#(
    parameter int BOOT_CYC_00 = rsec_pkg::BOOT_DLY_80_CYC,   // shorten in simulation
    parameter int BOOT_CYC_01 = rsec_pkg::BOOT_DLY_120_CYC,
    parameter int BOOT_CYC_10 = rsec_pkg::BOOT_DLY_220_CYC,
    parameter int BOOT_CYC_11 = rsec_pkg::BOOT_DLY_420_CYC
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic reg_wr,                     // register write strobe
    input wire logic reg_rd,                     // register read strobe
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,                // valid the cycle after reg_rd
    input wire rsec_pkg::rsec_slots_t slots,     // read-only factory codes
    input wire logic [3:0] mpc_pin,              // multipurpose pin levels, async
    input wire logic [1:0] boot_delay_select,    // strap, async
    input wire logic boot_start,                 // pulse: power-on boot begins
    input wire logic hard_reset,                 // level: device in hard reset
    input wire logic off_mode,                   // level: device entering off
    output logic reg3_enable,
    output logic switch1_enable,
    output logic switch2_enable,
    output logic reg2_pin_enable,
    output rsec_pkg::rsec_ctrl_t ctrl
);
    import rsec_pkg::*;

    rsec_state_t cur_ff;   // all registered state
    rsec_state_t nxt_cur;  // next value of the state

    // total boot length for a delay code
    function automatic logic [CNT_W-1:0] dly_cycles(input logic [1:0] code);
        logic [CNT_W-1:0] r;
        r = CNT_W'(BOOT_CYC_00);
        case (code)
            2'h1: r = CNT_W'(BOOT_CYC_01);
            2'h2: r = CNT_W'(BOOT_CYC_10);
            2'h3: r = CNT_W'(BOOT_CYC_11);
            default: r = CNT_W'(BOOT_CYC_00);
        endcase
        return r;
    endfunction

    // enable from slot code, software code and pin selection; shared by all outputs
    function automatic logic slot_enable(input logic [2:0] slot, input logic [1:0] code,
                                         input logic [3:0] sel, input logic [3:0] pins,
                                         input logic started, input logic [2:0] mile);
        logic r;
        r = 1'b0;
        case (slot)
            SLOT_AT0: r = started;
            SLOT_AT25: r = mile[0];
            SLOT_AT50: r = mile[1];
            // reserved software code 11 keeps the output off
            SLOT_SW: r = mile[2] & ((code == EN_ON) | ((code == EN_PIN) & (|(sel & pins))));
            default: r = 1'b0;  // disabled and reserved slot codes
        endcase
        return r;
    endfunction

    logic [CNT_W-1:0] total;    // boot length of the captured delay code
    logic started;              // boot sequencing has begun
    logic r3_fn_on;             // pin zero dedicated function active
    logic r3_fn_en;             // pin zero drives reg3 enable
    logic r3_req_mode;          // mode asked for this cycle
    logic [3:0] raw_en;         // enables before hard reset override

    // source selection for each output
    always_comb
    begin
        total = dly_cycles(cur_ff.dly_sel);
        started = (cur_ff.boot != BOOT_IDLE);
        r3_fn_on = cur_ff.r3_fn[1];
        r3_fn_en = r3_fn_on & cur_ff.r3_fn[0];
        // pin low picks regulating, pin high switch mode; enable role forces switch
        r3_req_mode = r3_fn_on ? (cur_ff.r3_fn[0] | cur_ff.pin_sync[0])
                               : cur_ff.r3_cfg[CFG_MODE_BIT];
        raw_en[IDX_R3] = r3_fn_en ? cur_ff.pin_sync[0]
                       : slot_enable(slots.reg3_boot_slot, cur_ff.r3_cfg[CFG_EN_MSB:CFG_EN_LSB],
                                     cur_ff.r3_pin, cur_ff.pin_sync, started, cur_ff.mile);
        raw_en[IDX_S1] = slot_enable(slots.switch1_boot_slot, cur_ff.s1_cfg[CFG_EN_MSB:CFG_EN_LSB],
                                     cur_ff.s1_pin, cur_ff.pin_sync, started, cur_ff.mile);
        raw_en[IDX_S2] = slot_enable(slots.switch2_boot_slot, cur_ff.s2_cfg[CFG_EN_MSB:CFG_EN_LSB],
                                     cur_ff.s2_pin, cur_ff.pin_sync, started, cur_ff.mile);
        raw_en[IDX_R2] = slot_enable(slots.reg2_boot_slot, slots.reg2_sw_enable_code,
                                     cur_ff.r2_pin, cur_ff.pin_sync, started, cur_ff.mile);
    end

    // next-state logic: synchronisers, registers, boot timer, outputs
    always_comb
    begin
        nxt_cur = cur_ff;
        // two-stage synchronisers; only the second stage is read
        nxt_cur.pin_meta = mpc_pin;
        nxt_cur.pin_sync = cur_ff.pin_meta;
        nxt_cur.dly_meta = boot_delay_select;
        nxt_cur.dly_sync = cur_ff.dly_meta;

        // register writes; slot fields and reserved bits are not writable
        if (reg_wr)
        begin
            unique case (reg_addr)
                REG3_CONFIG_OFS: nxt_cur.r3_cfg = reg_wdata[4:0];
                REG3_VOLTAGE_CODE_OFS: nxt_cur.r3_vcode = reg_wdata[5:0];
                REG3_PIN_CONTROL_OFS:
                begin
                    nxt_cur.r3_fn = reg_wdata[PIN_FN_ENABLE_BIT:PIN_FN_SELECT_BIT];
                    nxt_cur.r3_pin = reg_wdata[3:0];
                end
                SWITCH1_CONFIG_OFS: nxt_cur.s1_cfg = reg_wdata[4:0];
                SWITCH1_PIN_CONTROL_OFS: nxt_cur.s1_pin = reg_wdata[3:0];
                SWITCH2_CONFIG_OFS: nxt_cur.s2_cfg = reg_wdata[4:0];
                SWITCH2_PIN_CONTROL_OFS: nxt_cur.s2_pin = reg_wdata[3:0];
                REG2_PIN_CONTROL_OFS: nxt_cur.r2_pin = reg_wdata[3:0];
                default: ;  // unmapped writes are dropped
            endcase
        end

        // registered read data; unmapped addresses read zero
        if (reg_rd)
        begin
            unique case (reg_addr)
                REG3_CONFIG_OFS: nxt_cur.rdata = {slots.reg3_boot_slot, cur_ff.r3_cfg};
                REG3_VOLTAGE_CODE_OFS: nxt_cur.rdata = {2'h0, cur_ff.r3_vcode};
                REG3_PIN_CONTROL_OFS: nxt_cur.rdata = {cur_ff.r3_fn, 2'h0, cur_ff.r3_pin};
                SWITCH1_CONFIG_OFS: nxt_cur.rdata = {slots.switch1_boot_slot, cur_ff.s1_cfg};
                SWITCH1_PIN_CONTROL_OFS: nxt_cur.rdata = {4'h0, cur_ff.s1_pin};
                SWITCH2_CONFIG_OFS: nxt_cur.rdata = {slots.switch2_boot_slot, cur_ff.s2_cfg};
                SWITCH2_PIN_CONTROL_OFS: nxt_cur.rdata = {4'h0, cur_ff.s2_pin};
                REG2_PIN_CONTROL_OFS: nxt_cur.rdata = {4'h0, cur_ff.r2_pin};
                default: nxt_cur.rdata = 8'h00;
            endcase
        end

        // boot timer: milestones at 25%, 50% and 100% of the chosen delay
        unique case (cur_ff.boot)
            BOOT_IDLE:
            begin
                if (boot_start)
                begin
                    nxt_cur.boot = BOOT_RUN;
                    nxt_cur.cnt = CNT_RESET;
                    nxt_cur.dly_sel = cur_ff.dly_sync;
                end
            end
            BOOT_RUN:
            begin
                nxt_cur.cnt = cur_ff.cnt + CNT_W'(1);
                if (cur_ff.cnt == (total >> 2))
                    nxt_cur.mile[0] = 1'b1;
                if (cur_ff.cnt == (total >> 1))
                    nxt_cur.mile[1] = 1'b1;
                if (cur_ff.cnt == total - CNT_W'(1))
                begin
                    nxt_cur.mile = 3'h7;
                    nxt_cur.boot = BOOT_DONE;
                end
            end
            BOOT_DONE: ;  // stays until hard reset
        endcase
        // hard reset sends sequencing back to idle, overriding boot_start; a new boot_start pulse is needed
        if (hard_reset)
        begin
            nxt_cur.boot = BOOT_IDLE;
            nxt_cur.mile = 3'h0;
            nxt_cur.cnt = CNT_RESET;
        end

        // enables, forced off in hard reset
        nxt_cur.en = raw_en & {4{~hard_reset}};
        // mode is only taken while the regulator is off, so it never flips under load
        if (!cur_ff.en[IDX_R3])
            nxt_cur.r3_mode = r3_req_mode;

        // active discharge: hard reset, or optionally whenever the enable is low
        nxt_cur.act[IDX_R3] = hard_reset | (cur_ff.r3_cfg[CFG_ACT_BIT] & ~nxt_cur.en[IDX_R3]);
        nxt_cur.act[IDX_S1] = hard_reset | (cur_ff.s1_cfg[CFG_ACT_BIT] & ~nxt_cur.en[IDX_S1]);
        nxt_cur.act[IDX_S2] = hard_reset | (cur_ff.s2_cfg[CFG_ACT_BIT] & ~nxt_cur.en[IDX_S2]);
        // passive discharge: off or hard reset, or optionally while the enable is low
        nxt_cur.psv[IDX_R3] = hard_reset | off_mode
                            | (cur_ff.r3_cfg[CFG_PSV_BIT] & ~nxt_cur.en[IDX_R3]);
        nxt_cur.psv[IDX_S1] = hard_reset | off_mode
                            | (cur_ff.s1_cfg[CFG_PSV_BIT] & ~nxt_cur.en[IDX_S1]);
        nxt_cur.psv[IDX_S2] = hard_reset | off_mode
                            | (cur_ff.s2_cfg[CFG_PSV_BIT] & ~nxt_cur.en[IDX_S2]);
    end

    // single state register, synchronous reset
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            cur_ff <= '0;
            cur_ff.r3_cfg <= CFG_RESET;
            cur_ff.r3_vcode <= VCODE_RESET;
            cur_ff.r3_fn <= R3_FN_RESET;
            cur_ff.r3_pin <= R3_PIN_RESET;
            cur_ff.s1_cfg <= CFG_RESET;
            cur_ff.s1_pin <= SW_PIN_RESET;
            cur_ff.s2_cfg <= CFG_RESET;
            cur_ff.s2_pin <= SW_PIN_RESET;
            cur_ff.r2_pin <= R2_PIN_RESET;
            cur_ff.boot <= BOOT_IDLE;
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    // outputs straight from flip-flops
    always_comb
    begin
        reg_rdata = cur_ff.rdata;
        reg3_enable = cur_ff.en[IDX_R3];
        switch1_enable = cur_ff.en[IDX_S1];
        switch2_enable = cur_ff.en[IDX_S2];
        reg2_pin_enable = cur_ff.en[IDX_R2];
        ctrl.active_discharge = cur_ff.act;
        ctrl.passive_discharge = cur_ff.psv;
        ctrl.reg3_switch_mode = cur_ff.r3_mode;
        ctrl.switch1_low_quiescent = cur_ff.s1_cfg[CFG_MODE_BIT];
        ctrl.switch2_low_quiescent = cur_ff.s2_cfg[CFG_MODE_BIT];
        ctrl.reg3_voltage_code = cur_ff.r3_vcode;
    end

    // checks
    a_slot_off_holds: assert property (@(posedge sys_clk) disable iff (rst)
        (slots.reg2_boot_slot == SLOT_OFF) |=> !reg2_pin_enable)
        else $error("reg2 pins act with disabled slot");
    a_sw_code_on: assert property (@(posedge sys_clk) disable iff (rst)
        (slots.switch2_boot_slot == SLOT_SW && cur_ff.mile[2] && !hard_reset
         && cur_ff.s2_cfg[CFG_EN_MSB:CFG_EN_LSB] == EN_ON) |=> switch2_enable)
        else $error("switch2 not on with software code on");
    a_pin_or_en: assert property (@(posedge sys_clk) disable iff (rst)
        (slots.switch1_boot_slot == SLOT_SW && cur_ff.mile[2] && !hard_reset
         && cur_ff.s1_cfg[CFG_EN_MSB:CFG_EN_LSB] == EN_PIN)
        |=> (switch1_enable == |($past(cur_ff.s1_pin) & $past(cur_ff.pin_sync))))
        else $error("switch1 not following selected pins");
    a_mode_hold: assert property (@(posedge sys_clk) disable iff (rst)
        reg3_enable |=> $stable(ctrl.reg3_switch_mode))
        else $error("reg3 mode changed while enabled");
    a_act_dsc_off: assert property (@(posedge sys_clk) disable iff (rst)
        (!cur_ff.r3_cfg[CFG_ACT_BIT] && !hard_reset) |=> !ctrl.active_discharge[IDX_R3])
        else $error("reg3 active discharge without cause");
    a_psv_dsc_on: assert property (@(posedge sys_clk) disable iff (rst)
        (off_mode || hard_reset) |=> ctrl.passive_discharge[IDX_S2])
        else $error("switch2 passive discharge missing");
    a_hard_rst_off: assert property (@(posedge sys_clk) disable iff (rst)
        hard_reset |=> !reg3_enable && !switch1_enable && !switch2_enable && !reg2_pin_enable)
        else $error("output on during hard reset");
    a_pin0_enable: assert property (@(posedge sys_clk) disable iff (rst)
        (cur_ff.r3_fn == 2'h3 && !hard_reset) |=> (reg3_enable == $past(cur_ff.pin_sync[0])))
        else $error("reg3 not following pin zero");
    a_vcode_write: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_wr && reg_addr == REG3_VOLTAGE_CODE_OFS) |=> ctrl.reg3_voltage_code == $past(reg_wdata[5:0]))
        else $error("voltage code not stored");
    a_boot_quarter: assert property (@(posedge sys_clk) disable iff (rst)
        (cur_ff.boot == BOOT_RUN && cur_ff.cnt == (total >> 2) && !hard_reset) |=> cur_ff.mile[0])
        else $error("quarter milestone missed");
endmodule // rsec_top

// file: sim/rsec_pin_board.sv
`timescale 1ns/1ps
// far side: board pins and the boot-delay strap, moving off the device clock
module rsec_pin_board
(
    input wire logic [3:0] pin_req,
    input wire logic [1:0] strap_req,
    output wire logic [3:0] mpc_pin,
    output wire logic [1:0] boot_delay_select
);
    // odd delays put pin edges between clock edges, so the synchroniser earns its keep
    assign #7 mpc_pin = pin_req;
    // strap settles long before boot starts, yet still arrives unaligned
    assign #11 boot_delay_select = strap_req;
endmodule // rsec_pin_board

// file: sim/tb.sv
`timescale 1ns/1ps
module tb;
    import rsec_pkg::*;
    int tot[4] = '{40, 60, 110, 210}; // shortened boot delays
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    rsec_slots_t slots = {3'h2, 3'h3, 3'h4, 3'h0, 2'h0}; // staged codes first
    logic [3:0] pin_req = 4'h0;
    logic [1:0] strap_req = 2'h0;
    logic [3:0] mpc_pin;
    logic [1:0] boot_delay_select;
    logic boot_start = 1'b0;
    logic hard_reset = 1'b0;
    logic off_mode = 1'b0;
    logic reg3_enable, switch1_enable, switch2_enable, reg2_pin_enable;
    rsec_ctrl_t ctrl;
    int fail_count = 0;
    int checked = 0;
    logic [31:0] lfsr = 32'h00012E9E; // fixed seed keeps runs repeatable

    rsec_pin_board u_board (.pin_req(pin_req), .strap_req(strap_req), .mpc_pin(mpc_pin),
        .boot_delay_select(boot_delay_select));
    rsec_top #(.BOOT_CYC_00(40), .BOOT_CYC_01(60), .BOOT_CYC_10(110), .BOOT_CYC_11(210)) u_dut (
        .sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .slots(slots), .mpc_pin(mpc_pin),
        .boot_delay_select(boot_delay_select), .boot_start(boot_start), .hard_reset(hard_reset),
        .off_mode(off_mode), .reg3_enable(reg3_enable), .switch1_enable(switch1_enable),
        .switch2_enable(switch2_enable), .reg2_pin_enable(reg2_pin_enable), .ctrl(ctrl));

    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;

    // next random byte from the shift register
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction
    // enable chosen by a software code, pins only count when selected
    function automatic logic exp_en(input logic [1:0] code, input logic [7:0] sel, input logic [7:0] pins);
        case (code)
            2'h1: return 1'b1;
            2'h2: return |(sel[3:0] & pins[3:0]);
            default: return 1'b0; // off and the reserved code
        endcase
    endfunction
    task automatic chk(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // one-cycle write strobe, changed on falling edges only
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        cyc(1);
        reg_wr = 1'b0;
        cyc(1); // idle edge, so a following call never re-raises the strobe in this time step
    endtask
    // read data holds until the next read, so sampling late is safe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        reg_rd = 1'b1;
        reg_addr = a;
        cyc(1);
        reg_rd = 1'b0;
        cyc(2);
        chk_byte(reg_rdata, exp);
    endtask
    task automatic pulse_boot();
        boot_start = 1'b1;
        cyc(1);
        boot_start = 1'b0;
    endtask
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // watchdog: whole sequence needs about 1200 cycles
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        complete_run();
    end

    initial
    begin
        logic [7:0] c3, c1, c2, s3, s1, s2, sr, pins, v;
        logic [2:0] e;
        int n;
        cyc(5);
        rst = 1'b0;
        // reset values, read-only slot bits, unmapped places
        rd_chk(8'h40, 8'h02);
        rd_chk(8'h41, 8'h41);
        rd_chk(8'h43, 8'h04);
        rd_chk(8'h44, 8'h61);
        rd_chk(8'h45, 8'h00);
        rd_chk(8'h46, 8'h81);
        rd_chk(8'h47, 8'h00);
        wr(8'h48, 8'hFF);
        rd_chk(8'h48, 8'h00);
        wr(REG3_CONFIG_OFS, 8'hFF);
        rd_chk(8'h41, 8'h5F);
        wr(REG3_CONFIG_OFS, 8'h01);
        chk(reg3_enable, 1'b0);
        // staged boot: on at start, at a quarter, at half
        pulse_boot();
        cyc(5);
        chk(reg3_enable, 1'b1);
        chk(switch1_enable, 1'b0);
        cyc(10);
        chk(switch1_enable, 1'b1);
        chk(switch2_enable, 1'b0);
        cyc(10);
        chk(switch2_enable, 1'b1);
        chk(reg2_pin_enable, 1'b0);
        cyc(25);
        slots = {3'h7, 3'h7, 3'h7, 3'h7, 2'h2};
        // random software codes, pin selections, discharge and voltage settings
        for (int i = 0; i < 24; i++)
        begin
            c3 = rnd(); c1 = rnd(); c2 = rnd(); s3 = rnd(); s1 = rnd(); s2 = rnd(); sr = rnd();
            pins = rnd(); v = rnd();
            wr(REG3_CONFIG_OFS, c3);
            wr(SWITCH1_CONFIG_OFS, c1);
            wr(SWITCH2_CONFIG_OFS, c2);
            wr(REG3_PIN_CONTROL_OFS, {4'h0, s3[3:0]});
            wr(SWITCH1_PIN_CONTROL_OFS, {4'h0, s1[3:0]});
            wr(SWITCH2_PIN_CONTROL_OFS, {4'h0, s2[3:0]});
            wr(REG2_PIN_CONTROL_OFS, {4'h0, sr[3:0]});
            wr(REG3_VOLTAGE_CODE_OFS, {2'h0, v[5:0]});
            pin_req = pins[3:0];
            off_mode = v[7];
            cyc(6);
            e = {exp_en(c2[4:3], s2, pins), exp_en(c1[4:3], s1, pins), exp_en(c3[4:3], s3, pins)};
            chk(reg3_enable, e[0]);
            chk(switch1_enable, e[1]);
            chk(switch2_enable, e[2]);
            chk(reg2_pin_enable, |(sr[3:0] & pins[3:0]));
            chk_byte({5'h0, ctrl.active_discharge}, {5'h0, {c2[2], c1[2], c3[2]} & ~e});
            chk_byte({5'h0, ctrl.passive_discharge}, {5'h0, v[7] ? 3'h7 : {c2[0], c1[0], c3[0]} & ~e});
            chk(ctrl.switch1_low_quiescent, c1[1]);
            chk(ctrl.switch2_low_quiescent, c2[1]);
            if (!e[0])
                chk(ctrl.reg3_switch_mode, c3[1]);
            chk_byte({2'h0, ctrl.reg3_voltage_code}, {2'h0, v[5:0]});
            rd_chk(SWITCH1_PIN_CONTROL_OFS, {4'h0, s1[3:0]});
        end
        off_mode = 1'b0;
        // pin zero takes over the enable, then the mode
        wr(REG3_CONFIG_OFS, 8'h00);
        wr(REG3_PIN_CONTROL_OFS, 8'hC1);
        pin_req = 4'h1;
        cyc(6);
        chk(reg3_enable, 1'b1);
        chk(ctrl.reg3_switch_mode, 1'b1);
        pin_req = 4'h0;
        cyc(6);
        chk(reg3_enable, 1'b0);
        wr(REG3_PIN_CONTROL_OFS, 8'h40);
        pin_req = 4'h1;
        cyc(6);
        chk(reg3_enable, 1'b0);
        wr(REG3_PIN_CONTROL_OFS, 8'h80);
        cyc(6);
        chk(ctrl.reg3_switch_mode, 1'b1);
        pin_req = 4'h0;
        cyc(6);
        chk(ctrl.reg3_switch_mode, 1'b0);
        // mode may only change while the regulator is off
        wr(REG3_PIN_CONTROL_OFS, 8'h00);
        wr(REG3_CONFIG_OFS, 8'h08);
        cyc(6);
        wr(REG3_CONFIG_OFS, 8'h0A);
        cyc(6);
        chk(ctrl.reg3_switch_mode, 1'b0);
        wr(REG3_CONFIG_OFS, 8'h02);
        cyc(6);
        chk(ctrl.reg3_switch_mode, 1'b1);
        // each boot-delay code: hard reset, then time the hand-over
        wr(SWITCH2_CONFIG_OFS, 8'h08);
        for (int d = 0; d < 4; d++)
        begin
            hard_reset = 1'b1;
            strap_req = d[1:0];
            cyc(4);
            chk(switch2_enable, 1'b0);
            chk_byte({5'h0, ctrl.active_discharge}, 8'h07);
            chk_byte({5'h0, ctrl.passive_discharge}, 8'h07);
            hard_reset = 1'b0;
            cyc(2);
            pulse_boot();
            n = 0;
            while (switch2_enable !== 1'b1 && n < 400)
            begin
                cyc(1);
                n++;
            end
            // done flag one edge after the last count, enable one edge later
            chk(n == tot[d] + 1, 1'b1);
        end
        complete_run();
    end
endmodule // tb
